// File: logic/chfl_pkg.sv
package chfl_pkg;
   // Register indices on the device register port
   localparam logic [6:0] CHFL_LATCHED_OFS = 7'h2E;
   localparam logic [6:0] CHFL_LIVE_OFS = 7'h2F;
   localparam logic [6:0] CHFL_MASK_OFS = 7'h3C;

   // Field positions
   localparam int CHFL_CHAN_A_BIT = 0;
   localparam int CHFL_DIG_SUPPLY_BIT = 8;
   localparam int CHFL_CORE_LDO_BIT = 9;
   localparam int CHFL_CONV_DONE_BIT = 14;

   // Reset values and write masks
   localparam logic [15:0] CHFL_LATCHED_RST = 16'h0000;
   localparam logic [15:0] CHFL_MASK_RST = 16'h0000;
   localparam logic [15:0] CHFL_MASK_WMASK = 16'h7FFF;
   localparam logic [15:0] CHFL_LATCHED_WMASK = 16'h0301;

   // Timing
   localparam int unsigned CHFL_CLK_MHZ = 250;
   localparam int unsigned CHFL_OUT_DEBOUNCE_MS = 2;
   localparam int unsigned CHFL_OUT_DEBOUNCE_CYC = CHFL_OUT_DEBOUNCE_MS * CHFL_CLK_MHZ * 1000;
   localparam int unsigned CHFL_DONE_PULSE_US = 24;
   localparam int unsigned CHFL_DONE_PULSE_CYC = CHFL_DONE_PULSE_US * CHFL_CLK_MHZ;
   localparam int CHFL_DB_W = 20;
   localparam int CHFL_PULSE_W = 16;

   // Channel function codes
   typedef enum logic [3:0] {
      CHFL_FN_HIGH_Z = 4'h0,
      CHFL_FN_VOLT_OUT = 4'h1,
      CHFL_FN_CURR_OUT = 4'h2,
      CHFL_FN_VOLT_IN = 4'h3,
      CHFL_FN_CURR_IN_EXT = 4'h4,
      CHFL_FN_CURR_IN_LOOP = 4'h5
   } chfl_func_t;

   // Current conversion source codes
   localparam logic [2:0] CHFL_SRC_CHAN_A = 3'h0;
   localparam logic [2:0] CHFL_SRC_DIAG_0 = 3'h4;

   typedef struct packed {
      logic reserved15;
      logic conv_done;
      logic conv_busy;
      logic [2:0] conv_source;
      logic core_ldo_live;
      logic digital_supply_live;
      logic [6:0] reserved7_1;
      logic chan_a_fault_live;
   } chfl_live_t;

   typedef struct packed {
      logic enable;
      logic invert;
      logic [CHFL_DB_W-1:0] debounce_cyc;
   } chfl_comp_cfg_t;
endpackage

// File: logic/chfl_debounce.sv
`timescale 1ns/1ps
module chfl_debounce
   import chfl_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic cond,
   input wire logic [CHFL_DB_W-1:0] period,
   output logic hit
);
   logic [CHFL_DB_W-1:0] cnt_q;
   logic [CHFL_DB_W-1:0] limit;

   // A zero period still needs one sampled cycle of the condition
   assign limit = (period == '0) ? {{(CHFL_DB_W-1){1'b0}}, 1'b1} : period;

   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_q <= '0;
         hit <= 1'b0;
      end else if (ce) begin
         if (!cond) begin
            cnt_q <= '0;
            hit <= 1'b0;
         end else if (cnt_q + 1'b1 >= limit) begin
            cnt_q <= limit;
            hit <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end
endmodule

// File: logic/chfl_top.sv
// What this block does
// - Voltage output short flagged after 2 ms
// - Current output open flagged after 2 ms
// - Loop-powered input: inverted comparator flags ground short
// - Externally powered input: comparator flags overcurrent
// - Channel A fault source follows function select
// - Live register shows unlatched present conditions, plus the held conversion-done flag in bit 14
// - Conversion finish sets conversion-done flag
// - Conversion-done flag cleared only by writing one
// - Single mode: done pin mirrors the flag
// - Continuous mode: done pin released after 24 us
// - Bit 9 shows live core regulator fault
// - Bit 8 shows live digital supply fault
// - Bit 0 shows live channel A fault
// - Unmasked latched faults drive the alert pin
`timescale 1ns/1ps
module chfl_top
   import chfl_pkg::*;
#(
   parameter int unsigned OUT_DEBOUNCE_CYC = CHFL_OUT_DEBOUNCE_CYC,
   parameter int unsigned DONE_PULSE_CYC = CHFL_DONE_PULSE_CYC
)(
   input wire logic CLK_SYS,
   input wire logic SRST,
   input wire logic CE,
   input wire logic WR_EN,
   input wire logic [6:0] WR_ADDR,
   input wire logic [15:0] WR_DATA,
   input wire logic [6:0] RD_ADDR,
   output logic [15:0] RD_DATA,
   input wire logic [3:0] CHAN_A_FUNCTION_SELECT,
   input wire logic INPUT_COMPARATOR_ENABLE,
   input wire logic INPUT_COMPARATOR_INVERT,
   input wire logic [CHFL_DB_W-1:0] INPUT_COMPARATOR_DEBOUNCE,
   input wire logic SHORT_DETECT_RAW,
   input wire logic OPEN_DETECT_RAW,
   input wire logic COMPARATOR_RAW,
   input wire logic CORE_LDO_FAULT_RAW,
   input wire logic DIGITAL_SUPPLY_FAULT_RAW,
   input wire logic CONV_DONE,
   input wire logic CONV_BUSY,
   input wire logic [2:0] CONV_SOURCE,
   input wire logic CONTINUOUS_MODE,
   output logic CONV_DONE_N,
   output logic ALERT_N
);
   localparam logic [CHFL_DB_W-1:0] OUT_DB = CHFL_DB_W'(OUT_DEBOUNCE_CYC);
   localparam logic [CHFL_PULSE_W-1:0] PULSE_LEN = CHFL_PULSE_W'(DONE_PULSE_CYC);

   // Pin-level inputs from the analog side pass two flops first
   logic [4:0] raw_in;
   logic [4:0] sync1_q;
   logic [4:0] sync2_q;
   assign raw_in = {DIGITAL_SUPPLY_FAULT_RAW, CORE_LDO_FAULT_RAW, COMPARATOR_RAW,
                    OPEN_DETECT_RAW, SHORT_DETECT_RAW};

   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_sync
         always_ff @(posedge CLK_SYS) begin
            if (SRST) begin
               sync1_q[gi] <= 1'b0;
               sync2_q[gi] <= 1'b0;
            end else if (CE) begin
               sync1_q[gi] <= raw_in[gi];
               sync2_q[gi] <= sync1_q[gi];
            end
         end
      end
   endgenerate

   logic short_s;
   logic open_s;
   logic comp_s;
   logic core_ldo_fault;
   logic digital_supply_fault;
   assign short_s = sync2_q[0];
   assign open_s = sync2_q[1];
   assign comp_s = sync2_q[2];
   assign core_ldo_fault = sync2_q[3];
   assign digital_supply_fault = sync2_q[4];

   chfl_comp_cfg_t comp_cfg;
   assign comp_cfg = '{enable: INPUT_COMPARATOR_ENABLE, invert: INPUT_COMPARATOR_INVERT,
                       debounce_cyc: INPUT_COMPARATOR_DEBOUNCE};

   // Fault condition and debounce period chosen per function
   logic fault_cond;
   logic [CHFL_DB_W-1:0] fault_period;
   logic comp_eff;
   assign comp_eff = comp_s ^ comp_cfg.invert;

   always_comb begin
      fault_cond = 1'b0;
      fault_period = OUT_DB;
      case (chfl_func_t'(CHAN_A_FUNCTION_SELECT))
         CHFL_FN_VOLT_OUT: begin
            fault_cond = short_s;
            fault_period = OUT_DB;
         end
         CHFL_FN_CURR_OUT: begin
            fault_cond = open_s;
            fault_period = OUT_DB;
         end
         CHFL_FN_CURR_IN_LOOP: begin
            // Only meaningful with the comparator inverted
            fault_cond = comp_cfg.enable & comp_cfg.invert & comp_eff;
            fault_period = comp_cfg.debounce_cyc;
         end
         CHFL_FN_CURR_IN_EXT: begin
            fault_cond = comp_cfg.enable & comp_eff;
            fault_period = comp_cfg.debounce_cyc;
         end
         default: begin
            fault_cond = 1'b0;
            fault_period = OUT_DB;
         end
      endcase
   end

   // A function change restarts debounce only when the newly selected condition is low
   logic chan_a_fault_live;
   chfl_debounce u_debounce (
      .clk(CLK_SYS),
      .srst(SRST),
      .ce(CE),
      .cond(fault_cond),
      .period(fault_period),
      .hit(chan_a_fault_live)
   );

   logic wr_latched;
   logic wr_live;
   logic wr_mask;
   always_comb begin
      wr_latched = 1'b0;
      wr_live = 1'b0;
      wr_mask = 1'b0;
      if (WR_EN && WR_ADDR == CHFL_LATCHED_OFS) begin
         wr_latched = 1'b1;
      end else if (WR_EN && WR_ADDR == CHFL_LIVE_OFS) begin
         wr_live = 1'b1;
      end else if (WR_EN && WR_ADDR == CHFL_MASK_OFS) begin
         wr_mask = 1'b1;
      end
   end

   // Latched faults: new events win over a same-cycle write-one clear
   logic [15:0] latched_q;
   logic [15:0] latched_set;
   logic [15:0] latched_clr;
   always_comb begin
      latched_set = 16'h0000;
      latched_set[CHFL_CHAN_A_BIT] = chan_a_fault_live;
      latched_set[CHFL_DIG_SUPPLY_BIT] = digital_supply_fault;
      latched_set[CHFL_CORE_LDO_BIT] = core_ldo_fault;
      latched_clr = wr_latched ? (WR_DATA & CHFL_LATCHED_WMASK) : 16'h0000;
   end

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         latched_q <= CHFL_LATCHED_RST;
      end else if (CE) begin
         latched_q <= (latched_q & ~latched_clr) | latched_set;
      end
   end

   logic [15:0] mask_q;
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         mask_q <= CHFL_MASK_RST;
      end else if (CE && wr_mask) begin
         mask_q <= WR_DATA & CHFL_MASK_WMASK;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         ALERT_N <= 1'b1;
      end else if (CE) begin
         ALERT_N <= ~|(latched_q & ~mask_q);
      end
   end

   // Conversion-done flag
   logic conv_done_q;
   logic done_clr;
   assign done_clr = wr_live & WR_DATA[CHFL_CONV_DONE_BIT];
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         conv_done_q <= 1'b0;
      end else if (CE) begin
         if (CONV_DONE) begin
            conv_done_q <= 1'b1;
         end else if (done_clr) begin
            conv_done_q <= 1'b0;
         end
      end
   end

   // Continuous-mode pulse timer; a new conversion restarts it
   logic [CHFL_PULSE_W-1:0] pulse_cnt_q;
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         pulse_cnt_q <= '0;
      end else if (CE) begin
         if (CONV_DONE && CONTINUOUS_MODE) begin
            pulse_cnt_q <= PULSE_LEN;
         end else if (!CONTINUOUS_MODE) begin
            pulse_cnt_q <= '0;
         end else if (pulse_cnt_q != '0) begin
            pulse_cnt_q <= pulse_cnt_q - 1'b1;
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         CONV_DONE_N <= 1'b1;
      end else if (CE) begin
         if (CONTINUOUS_MODE) begin
            CONV_DONE_N <= ~((CONV_DONE) || (pulse_cnt_q > CHFL_PULSE_W'(1)));
         end else begin
            CONV_DONE_N <= ~(CONV_DONE | (conv_done_q & ~done_clr));
         end
      end
   end

   // Live view is combinational from present conditions and the held conversion-done flag
   chfl_live_t live;
   always_comb begin
      live = '0;
      live.conv_done = conv_done_q;
      live.conv_busy = CONV_BUSY;
      live.conv_source = CONV_SOURCE;
      live.core_ldo_live = core_ldo_fault;
      live.digital_supply_live = digital_supply_fault;
      live.chan_a_fault_live = chan_a_fault_live;
   end

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         RD_DATA <= 16'h0000;
      end else if (CE) begin
         if (RD_ADDR == CHFL_LIVE_OFS) begin
            RD_DATA <= live;
         end else if (RD_ADDR == CHFL_LATCHED_OFS) begin
            RD_DATA <= latched_q;
         end else if (RD_ADDR == CHFL_MASK_OFS) begin
            RD_DATA <= mask_q;
         end else begin
            RD_DATA <= 16'h0000;
         end
      end
   end
endmodule

// File: tb/chfl_properties.sv
`timescale 1ns/1ps
module chfl_properties
   import chfl_pkg::*;
#(
   parameter int unsigned DONE_PULSE_CYC = 6
)(
   input wire logic CLK_SYS,
   input wire logic SRST,
   input wire logic CE,
   input wire logic WR_EN,
   input wire logic [6:0] WR_ADDR,
   input wire logic [15:0] WR_DATA,
   input wire logic [6:0] RD_ADDR,
   input wire logic [15:0] RD_DATA,
   input wire logic CONV_DONE,
   input wire logic CONV_BUSY,
   input wire logic [2:0] CONV_SOURCE,
   input wire logic CONTINUOUS_MODE,
   input wire logic CONV_DONE_N
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (SRST);
   logic [15:0] low_q;
   logic clr;
   logic lv;
   assign clr = CE && WR_EN && WR_ADDR == CHFL_LIVE_OFS && WR_DATA[14];
   assign lv = CE && RD_ADDR == CHFL_LIVE_OFS;
   // Length of the pin pulse in continuous mode
   always_ff @(posedge CLK_SYS) begin
      if (SRST || CONV_DONE_N || !CONTINUOUS_MODE) begin
         low_q <= 16'h0000;
      end else if (CE) begin
         low_q <= low_q + 16'h0001;
      end
   end
   property p_single_low;
      !CONTINUOUS_MODE && CE && CONV_DONE |=> !CONV_DONE_N;
   endproperty
   a_single_low: assert property (p_single_low)
      else $error("done pin not low after finish");
   property p_single_hold;
      !CONTINUOUS_MODE && CE && !CONV_DONE_N && !clr |=> !CONV_DONE_N;
   endproperty
   a_single_hold: assert property (p_single_hold)
      else $error("done pin released without clear");
   property p_clear;
      !CONTINUOUS_MODE && clr && !CONV_DONE |=> CONV_DONE_N;
   endproperty
   a_clear: assert property (p_clear)
      else $error("done pin stays low after clear");
   property p_cont_low;
      CONTINUOUS_MODE && CE && CONV_DONE |-> ##[1:2] !CONV_DONE_N;
   endproperty
   a_cont_low: assert property (p_cont_low)
      else $error("done pin not pulsed");
   property p_cont_len;
      low_q <= DONE_PULSE_CYC;
   endproperty
   a_cont_len: assert property (p_cont_len)
      else $error("done pulse too long");
   property p_busy;
      lv && $stable(CONV_BUSY) |=> RD_DATA[13] == $past(CONV_BUSY);
   endproperty
   a_busy: assert property (p_busy)
      else $error("busy bit wrong");
   property p_src;
      lv && $stable(CONV_SOURCE) |=> RD_DATA[12:10] == $past(CONV_SOURCE);
   endproperty
   a_src: assert property (p_src)
      else $error("source field wrong");
   property p_latched;
      CE && RD_ADDR == CHFL_LATCHED_OFS |=> (RD_DATA & ~CHFL_LATCHED_WMASK) == 16'h0000;
   endproperty
   a_latched: assert property (p_latched)
      else $error("latched spare bits set");
   c_cont: cover property (CONTINUOUS_MODE && CONV_DONE);
   c_clr: cover property (clr && !CONV_DONE_N);
   c_unmapped: cover property (CE && RD_ADDR == 7'h00);
endmodule
bind chfl_top chfl_properties #(.DONE_PULSE_CYC(DONE_PULSE_CYC)) u_props (
   .CLK_SYS(CLK_SYS), .SRST(SRST), .CE(CE), .WR_EN(WR_EN), .WR_ADDR(WR_ADDR),
   .WR_DATA(WR_DATA), .RD_ADDR(RD_ADDR), .RD_DATA(RD_DATA), .CONV_DONE(CONV_DONE),
   .CONV_BUSY(CONV_BUSY), .CONV_SOURCE(CONV_SOURCE), .CONTINUOUS_MODE(CONTINUOUS_MODE),
   .CONV_DONE_N(CONV_DONE_N));

// File: tb/chfl_host.sv
`timescale 1ns/1ps
module chfl_host (
   input wire logic clk,
   output logic wr_en,
   output logic [6:0] wr_addr,
   output logic [15:0] wr_data,
   output logic [6:0] rd_addr,
   output logic rd_req
);
   initial begin
      wr_en = 1'b0;
      wr_addr = 7'h00;
      wr_data = 16'h0000;
      rd_addr = 7'h00;
      rd_req = 1'b0;
   end
   // Clears go out as write-one words; idle bus shows inverted junk
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      @(negedge clk);
      wr_en = 1'b1;
      wr_addr = a;
      wr_data = d;
      @(negedge clk);
      wr_en = 1'b0;
      wr_addr = ~a;
      wr_data = ~d;
   endtask
   task automatic rd(input logic [6:0] a);
      @(negedge clk);
      rd_addr = a;
      rd_req = 1'b1;
      @(negedge clk);
      rd_req = 1'b0;
      rd_addr = ~a;
   endtask
endmodule

// File: tb/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin fails++; $display("BAD %s exp %h got %h", n, e, a); end end
module tb
   import chfl_pkg::*;
;
   logic clk = 1'b0;
   logic ce = 1'b1;
   logic srst = 1'b1;
   logic [3:0] func = 4'h0;
   logic cmp_en = 1'b0, cmp_inv = 1'b0, shrt = 1'b0, opn = 1'b0, cmp = 1'b0;
   logic ldo = 1'b0, dig = 1'b0, cdone = 1'b0, busy = 1'b0, cont = 1'b0;
   logic [2:0] src = 3'h0;
   logic [19:0] db = 20'h00004;
   logic [15:0] rdd, wd, e;
   logic [6:0] wa, ra;
   logic wen, rreq, req_q, done_n, alert_n;
   logic [15:0] exp_q[$];
   logic [9:0] tbl[8] = '{10'h061, 10'h050, 10'h091, 10'h0A0, 10'h10D, 10'h147, 10'h14E, 10'h108};
   logic [31:0] lfsr = 32'hB2F45491;
   int fails = 0, checks_done = 0, n;
   always #2 clk = ~clk;
   chfl_host host (.clk(clk), .wr_en(wen), .wr_addr(wa), .wr_data(wd), .rd_addr(ra),
      .rd_req(rreq));
   chfl_top #(.OUT_DEBOUNCE_CYC(8), .DONE_PULSE_CYC(6)) uut (
      .CLK_SYS(clk), .SRST(srst), .CE(ce), .WR_EN(wen), .WR_ADDR(wa), .WR_DATA(wd),
      .RD_ADDR(ra), .RD_DATA(rdd), .CHAN_A_FUNCTION_SELECT(func), .INPUT_COMPARATOR_ENABLE(cmp_en),
      .INPUT_COMPARATOR_INVERT(cmp_inv), .INPUT_COMPARATOR_DEBOUNCE(db), .SHORT_DETECT_RAW(shrt),
      .OPEN_DETECT_RAW(opn), .COMPARATOR_RAW(cmp), .CORE_LDO_FAULT_RAW(ldo),
      .DIGITAL_SUPPLY_FAULT_RAW(dig), .CONV_DONE(cdone), .CONV_BUSY(busy), .CONV_SOURCE(src),
      .CONTINUOUS_MODE(cont), .CONV_DONE_N(done_n), .ALERT_N(alert_n));
   always @(posedge clk) begin
      if (req_q === 1'b1) begin
         e = exp_q.pop_front();
         `CHK("rd_data", e, rdd)
      end
      req_q <= rreq;
   end
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic rd(input logic [6:0] a, input logic [15:0] x);
      exp_q.push_back(x);
      host.rd(a);
   endtask
   task automatic pulse_done();
      @(negedge clk);
      cdone = 1'b1;
      @(negedge clk);
      cdone = 1'b0;
   endtask
   task automatic wrap_up();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      wrap_up();
   end
   initial begin
      repeat (16) @(negedge clk);
      srst = 1'b0;
      rd(CHFL_LIVE_OFS, 16'h0000);
      `CHK("alert_n", 1'b1, alert_n)
      busy = 1'b1;
      for (int i = 0; i < 8; i++) begin
         src = i[2:0];
         host.wr(CHFL_LIVE_OFS, 16'h3C00);
         rd(CHFL_LIVE_OFS, {3'h1, i[2:0], 10'h000});
      end
      busy = 1'b0;
      // Later live reads expect an idle source field
      src = 3'h0;
      for (int b = 8; b < 10; b++) begin
         {ldo, dig} = (b == 9) ? 2'h2 : 2'h1;
         repeat (12) @(negedge clk);
         rd(CHFL_LIVE_OFS, 16'(1 << b));
         `CHK("alert_n", 1'b0, alert_n)
         host.wr(CHFL_MASK_OFS, 16'(1 << b));
         repeat (3) @(negedge clk);
         `CHK("alert_n", 1'b1, alert_n)
         {ldo, dig} = 2'h0;
         host.wr(CHFL_MASK_OFS, 16'h0000);
         repeat (12) @(negedge clk);
         rd(CHFL_LIVE_OFS, 16'h0000);
         rd(CHFL_LATCHED_OFS, 16'(1 << b));
         host.wr(CHFL_LATCHED_OFS, 16'(1 << b));
         rd(CHFL_LATCHED_OFS, 16'h0000);
         `CHK("alert_n", 1'b1, alert_n)
      end
      func = 4'h1;
      shrt = 1'b1;
      repeat (4) @(negedge clk);
      shrt = 1'b0;
      repeat (12) @(negedge clk);
      rd(CHFL_LATCHED_OFS, 16'h0000);
      foreach (tbl[k]) begin
         {func, shrt, opn, cmp, cmp_en, cmp_inv} = tbl[k][9:1];
         repeat (16) @(negedge clk);
         rd(CHFL_LIVE_OFS, {15'h0000, tbl[k][0]});
         rd(CHFL_LATCHED_OFS, {15'h0000, tbl[k][0]});
         {shrt, opn, cmp, cmp_en, cmp_inv} = 5'h00;
         repeat (6) @(negedge clk);
         host.wr(CHFL_LATCHED_OFS, 16'h0001);
      end
      pulse_done();
      rd(CHFL_LIVE_OFS, 16'h4000);
      `CHK("done_n", 1'b0, done_n)
      host.wr(CHFL_LIVE_OFS, 16'hBFFF);
      rd(CHFL_LIVE_OFS, 16'h4000);
      host.wr(CHFL_LIVE_OFS, 16'h4000);
      rd(CHFL_LIVE_OFS, 16'h0000);
      `CHK("done_n", 1'b1, done_n)
      cont = 1'b1;
      pulse_done();
      for (n = 0; n < 40 && done_n !== 1'b0; n++) @(negedge clk);
      for (n = 0; n < 40 && done_n === 1'b0; n++) @(negedge clk);
      `CHK("low cycles", 6, n)
      rd(CHFL_LIVE_OFS, 16'h4000);
      host.wr(CHFL_LIVE_OFS, 16'h4000);
      cont = 1'b0;
      lfsr = nxt(lfsr);
      host.wr(CHFL_MASK_OFS, lfsr[15:0]);
      rd(CHFL_MASK_OFS, lfsr[15:0] & CHFL_MASK_WMASK);
      rd(7'h00, 16'h0000);
      // Frozen block ignores a finish and a write
      ce = 1'b0;
      pulse_done();
      host.wr(CHFL_MASK_OFS, 16'h0000);
      repeat (2) @(negedge clk);
      ce = 1'b1;
      rd(CHFL_LIVE_OFS, 16'h0000);
      rd(CHFL_MASK_OFS, lfsr[15:0] & CHFL_MASK_WMASK);
      `CHK("done_n", 1'b1, done_n)
      repeat (3) @(negedge clk);
      wrap_up();
   end
endmodule
